// ---- hw/cfg_mode_ctrl.sv ----
// Mode controller: configuration request, store access, load on exit and gate control
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Store words carry a code correcting single and detecting double bit errors.
// R2: Host requests only with enable low, high inputs high, low inputs low, faults cleared.
// R3: A fault line low pulse of 2048 to 4096 internal periods requests configuration.
// R4: In configuration mode the serial port writes and reads the store.
// R5: Drive enable high leaves configuration mode.
// R6: On exit finish pending writes, then copy the whole store to working registers.
// R7: Fault line held low while finishing writes and copying.
// R8: Gates blocked after reset and after exit until the copy finishes.
// R9: Direct mode: each transistor follows its own gate input.
// R10: All high inputs high: low inputs drive bridges with programmed dead time.
// R11: Enable low forces every gate output low.
// R12: Drain-source and gate-source monitors are watched during operation.
// R13: Sleep switches on the gate discharge path on every gate.
// R14: Host brings gates low before sleep.
// R15: Host acknowledges by holding the fault line low; checked at each falling edge.
// R16: Acknowledge clears latched faults and releases the fault line.
// R17: Low pulse length is counted; pulses outside the window are ignored.
module cfg_mode_ctrl #(
   parameter int DEPTH       = 16,
   parameter int WRITE_TICKS = 64
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   input  wire logic                       driveEnable,
   input  wire logic                       faultIn,
   output logic                            faultOut,
   output logic                            faultOe,
   input  wire logic [2:0]                 highSideIn,
   input  wire logic [2:0]                 lowSideIn,
   input  wire logic                       spiClk,
   input  wire logic                       spiSelN,
   input  wire logic                       spiMosi,
   output logic                            spiMiso,
   output logic                            spiMisoOe,
   input  wire logic                       sleepReq,
   input  wire logic [5:0]                 drainSourceFlag,
   input  wire logic [5:0]                 gateSourceFlag,
   output var cfg_mode_pkg::gates_t        gates,
   output logic                            gateDischarge,
   output logic                            configActive,
   output logic                            faultLatched,
   output logic [DEPTH-1:0][7:0]           cfgWords
);
   localparam int AW = $clog2(DEPTH);

   logic [cfg_mode_pkg::SYNC_W-1:0]       pinRaw, sync1, sync2, sync3, pinF;
   logic                                  enF, lineLow, selN, sclkF, mosiF, sleepF;
   logic [2:0]                            hsF, lsF;
   logic [5:0]                            vdsF, vgsF;
   cfg_mode_pkg::mode_t                   stReg;
   logic [3:0]                            tickCnt;
   logic                                  tick;
   logic                                  lineLowPrev;
   logic [cfg_mode_pkg::LOW_CNT_W-1:0]    lowCnt;
   logic                                  pulseEnd, pulseOk, reqOk;
   logic [cfg_mode_pkg::REPORT_CNT_W-1:0] repCnt;
   logic                                  repLowPhase, repFall, ackDet, monHit;
   logic [cfg_mode_pkg::WRITE_CNT_W-1:0]  writeCnt;
   logic                                  writeBusy;
   logic                                  sclkPrev, selPrev;
   logic [4:0]                            bitCnt;
   logic [15:0]                           rxShift, txShift;
   logic                                  frameEnd;
   logic                                  memWe;
   logic [AW-1:0]                         memWAddr, spiAddrReg, memRAddr, loadAddrD;
   logic [cfg_mode_pkg::CODE_W-1:0]       memWData, memRData;
   cfg_mode_pkg::ecc_res_t                rdRes;
   logic                                  rdPend1, rdPend2, rdCorr, rdDbl;
   logic [7:0]                            rdData;
   logic [AW:0]                           loadIdx;
   logic                                  loadPend, loadDone, blocked, directMode;
   logic [2:0][7:0]                       deadCnt;
   logic [2:0]                            lsPrev;

   // Three-stage synchroniser; a change is taken once stages two and three agree
   assign pinRaw = {gateSourceFlag, drainSourceFlag, sleepReq, spiMosi, spiClk, spiSelN,
                    lowSideIn, highSideIn, faultIn, driveEnable};
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pinF  <= '0;
      end else begin
         sync1 <= pinRaw;
         sync2 <= sync1;
         sync3 <= sync2;
         pinF  <= (sync2 & sync3) | (pinF & (sync2 | sync3));
      end
   end
   assign enF     = pinF[0];
   assign lineLow = ~pinF[1];
   assign hsF     = pinF[4:2];
   assign lsF     = pinF[7:5];
   assign selN    = pinF[8];
   assign sclkF   = pinF[9];
   assign mosiF   = pinF[10];
   assign sleepF  = pinF[11];
   assign vdsF    = pinF[17:12];
   assign vgsF    = pinF[23:18];

   // Internal clock period as an enable pulse
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tickCnt <= 4'h0;
      end else if (tick) begin
         tickCnt <= 4'h0;
      end else begin
         tickCnt <= tickCnt + 4'h1;
      end
   end
   assign tick = (tickCnt == 4'(cfg_mode_pkg::TICK_DIV - 1));

   // Low pulse length on the fault line, counted only while the line is not driven here
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lowCnt      <= '0;
         lineLowPrev <= 1'b0;
      end else begin
         lineLowPrev <= lineLow & ~faultOe;
         if (!lineLow || faultOe) begin
            lowCnt <= '0;
         end else if (tick && lowCnt != '1) begin
            lowCnt <= lowCnt + 1'b1; // R17
         end
      end
   end
   assign pulseEnd = lineLowPrev & ~lineLow;
   assign pulseOk  = (lowCnt >= 13'(cfg_mode_pkg::PULSE_MIN_TICKS)) &&
                     (lowCnt <= 13'(cfg_mode_pkg::PULSE_MAX_TICKS)); // R3
   assign reqOk    = pulseEnd && pulseOk && !enF && (&hsF) && !(|lsF) && !faultLatched; // R2

   // Mode sequence
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stReg <= cfg_mode_pkg::ST_LOAD;
      end else begin
         case (stReg)
            cfg_mode_pkg::ST_NORMAL: begin
               if (reqOk) begin
                  stReg <= cfg_mode_pkg::ST_CONFIG; // R3
               end
            end
            cfg_mode_pkg::ST_CONFIG: begin
               if (enF) begin
                  stReg <= cfg_mode_pkg::ST_FINISH; // R5
               end
            end
            cfg_mode_pkg::ST_FINISH: begin
               if (!writeBusy && !memWe) begin
                  stReg <= cfg_mode_pkg::ST_LOAD; // R6
               end
            end
            cfg_mode_pkg::ST_LOAD: begin
               if (loadDone) begin
                  stReg <= cfg_mode_pkg::ST_NORMAL;
               end
            end
            default: stReg <= cfg_mode_pkg::ST_LOAD;
         endcase
      end
   end

   // Monitor faults, report pattern and acknowledge at each falling edge
   assign monHit      = (stReg == cfg_mode_pkg::ST_NORMAL) && enF && (|{vdsF, vgsF}); // R12
   assign repLowPhase = repCnt < 6'(cfg_mode_pkg::REPORT_LOW_TICKS);
   assign repFall     = tick &&
                        (repCnt == 6'(cfg_mode_pkg::REPORT_LOW_TICKS +
                                      cfg_mode_pkg::REPORT_HI_TICKS - 1));
   assign ackDet      = faultLatched && repFall && lineLow; // R15
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         faultLatched <= 1'b0;
         repCnt       <= '0;
      end else begin
         if (monHit) begin
            faultLatched <= 1'b1; // R12
         end else if (ackDet) begin
            faultLatched <= 1'b0; // R16
         end
         if (!faultLatched || repFall) begin
            repCnt <= '0;
         end else if (tick) begin
            repCnt <= repCnt + 1'b1;
         end
      end
   end

   // Fault line drive; open drain so the output level is a constant low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         faultOut <= 1'b0;
         faultOe  <= 1'b1;
      end else begin
         faultOut <= 1'b0;
         faultOe  <= (stReg == cfg_mode_pkg::ST_FINISH) || (stReg == cfg_mode_pkg::ST_LOAD) ||
                     (faultLatched && repLowPhase && !ackDet); // R7
      end
   end

   // Serial port, active only in configuration mode
   assign frameEnd = (stReg == cfg_mode_pkg::ST_CONFIG) && selN && !selPrev &&
                     (bitCnt == 5'(cfg_mode_pkg::SPI_FRAME_BITS));
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclkPrev  <= 1'b0;
         selPrev   <= 1'b1;
         bitCnt    <= '0;
         rxShift   <= '0;
         txShift   <= '0;
         spiMiso   <= 1'b0;
         spiMisoOe <= 1'b0;
      end else begin
         sclkPrev  <= sclkF;
         selPrev   <= selN;
         spiMisoOe <= (stReg == cfg_mode_pkg::ST_CONFIG) && !selN;
         if (stReg != cfg_mode_pkg::ST_CONFIG || selN) begin
            bitCnt <= '0;
         end else if (selPrev) begin
            txShift <= {rdDbl, rdCorr, writeBusy, 5'h00, rdData};
            spiMiso <= rdDbl;
         end else if (sclkF && !sclkPrev) begin
            rxShift <= {rxShift[14:0], mosiF}; // R4
            if (bitCnt != 5'h1f) begin
               bitCnt <= bitCnt + 5'h1;
            end
         end else if (!sclkF && sclkPrev) begin
            txShift <= {txShift[14:0], 1'b0};
            spiMiso <= txShift[14];
         end
      end
   end

   // Store write, write time and readback
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         memWe      <= 1'b0;
         memWAddr   <= '0;
         memWData   <= '0;
         spiAddrReg <= '0;
         rdPend1    <= 1'b0;
         rdPend2    <= 1'b0;
         writeCnt   <= '0;
      end else begin
         memWe   <= frameEnd && rxShift[cfg_mode_pkg::SPI_WRITE_BIT] && !writeBusy; // R4
         rdPend1 <= frameEnd && !rxShift[cfg_mode_pkg::SPI_WRITE_BIT];
         rdPend2 <= rdPend1;
         if (frameEnd) begin
            memWAddr   <= rxShift[cfg_mode_pkg::SPI_ADDR_LSB +: AW];
            spiAddrReg <= rxShift[cfg_mode_pkg::SPI_ADDR_LSB +: AW];
            memWData   <= cfg_mode_pkg::eccEncode(rxShift[7:0]); // R1
         end
         if (memWe) begin
            writeCnt <= 12'(WRITE_TICKS);
         end else if (tick && writeBusy) begin
            writeCnt <= writeCnt - 12'h001;
         end
      end
   end
   assign writeBusy = (writeCnt != '0);
   assign memRAddr  = (stReg == cfg_mode_pkg::ST_LOAD) ? loadIdx[AW-1:0] : spiAddrReg;
   assign rdRes     = cfg_mode_pkg::eccDecode(memRData); // R1

   cfg_store #(
      .AW (AW),
      .DW (cfg_mode_pkg::CODE_W)
   ) store (
      .clk   (ref_clk),
      .we    (memWe),
      .wAddr (memWAddr),
      .wData (memWData),
      .rAddr (memRAddr),
      .rData (memRData)
   );

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdData <= '0;
         rdCorr <= 1'b0;
         rdDbl  <= 1'b0;
      end else if (rdPend2) begin
         rdData <= rdRes.data;
         rdCorr <= rdRes.corrected;
         rdDbl  <= rdRes.dbl;
      end
   end

   // Copy the whole store into the working registers
   assign loadDone = (loadIdx == (AW+1)'(DEPTH)) && !loadPend;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loadIdx   <= '0;
         loadPend  <= 1'b0;
         loadAddrD <= '0;
         cfgWords  <= {DEPTH{cfg_mode_pkg::DEAD_RST}};
      end else begin
         loadPend  <= (stReg == cfg_mode_pkg::ST_LOAD) && (loadIdx < (AW+1)'(DEPTH));
         loadAddrD <= loadIdx[AW-1:0];
         if (stReg != cfg_mode_pkg::ST_LOAD) begin
            loadIdx <= '0;
         end else if (loadIdx < (AW+1)'(DEPTH)) begin
            loadIdx <= loadIdx + 1'b1; // R6
         end
         if (loadPend) begin
            cfgWords[loadAddrD] <= rdRes.data;
         end
      end
   end

   // Gate outputs
   // A fresh monitor hit blocks at once, before the latch has settled
   assign blocked    = (stReg != cfg_mode_pkg::ST_NORMAL) || !enF || faultLatched || sleepF ||
                       monHit; // R12
   assign directMode = !(&hsF);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         deadCnt <= '0;
         lsPrev  <= '0;
      end else begin
         lsPrev <= lsF;
         for (int i = 0; i < 3; i++) begin
            if (lsF[i] != lsPrev[i]) begin
               deadCnt[i] <= cfgWords[0]; // R10
            end else if (deadCnt[i] != 8'h00) begin
               deadCnt[i] <= deadCnt[i] - 8'h01;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gates         <= '0;
         gateDischarge <= 1'b0;
         configActive  <= 1'b0;
      end else begin
         gateDischarge <= sleepF; // R13
         configActive  <= (stReg == cfg_mode_pkg::ST_CONFIG);
         for (int i = 0; i < 3; i++) begin
            if (blocked) begin
               gates.high[i] <= 1'b0; // R8 R11
               gates.low[i]  <= 1'b0;
            end else if (directMode) begin
               gates.high[i] <= hsF[i]; // R9
               gates.low[i]  <= lsF[i];
            end else begin
               gates.high[i] <= !lsF[i] && (deadCnt[i] == 8'h00) && (lsF[i] == lsPrev[i]); // R10
               gates.low[i]  <= lsF[i] && (deadCnt[i] == 8'h00) && (lsF[i] == lsPrev[i]);
            end
         end
      end
   end

   // Checks
   sequence seqExitReq;
      stReg == cfg_mode_pkg::ST_CONFIG && enF;
   endsequence
   sequence seqFinishing;
      stReg == cfg_mode_pkg::ST_FINISH;
   endsequence

   AST_ENABLE_OFF: assert property (@(posedge ref_clk) disable iff (rst) // R11
      !enF |=> gates == '0) else $error("gates on while enable low");
   AST_LOAD_BLOCKS: assert property (@(posedge ref_clk) disable iff (rst) // R8
      stReg == cfg_mode_pkg::ST_LOAD |=> gates == '0) else $error("gates on during load");
   AST_EXIT_LOW: assert property (@(posedge ref_clk) disable iff (rst) // R7
      stReg inside {cfg_mode_pkg::ST_FINISH, cfg_mode_pkg::ST_LOAD} |=> faultOe)
      else $error("fault line released during exit");
   AST_EXIT: assert property (@(posedge ref_clk) disable iff (rst) // R5
      seqExitReq |=> seqFinishing) else $error("no exit on enable");
   AST_FINISH_WAIT: assert property (@(posedge ref_clk) disable iff (rst) // R6
      seqFinishing ##0 writeBusy |=> seqFinishing) else $error("left before write done");
   AST_PULSE_REJECT: assert property (@(posedge ref_clk) disable iff (rst) // R17
      stReg == cfg_mode_pkg::ST_NORMAL && pulseEnd &&
      lowCnt < 13'(cfg_mode_pkg::PULSE_MIN_TICKS)
      |=> stReg == cfg_mode_pkg::ST_NORMAL) else $error("short pulse accepted");
   AST_PULSE_ACCEPT: assert property (@(posedge ref_clk) disable iff (rst) // R3
      stReg == cfg_mode_pkg::ST_NORMAL && reqOk |=> ##[0:2] configActive)
      else $error("valid request ignored");
   AST_SLEEP: assert property (@(posedge ref_clk) disable iff (rst) // R13
      sleepF |=> gateDischarge && gates == '0) else $error("sleep without discharge");
   AST_ECC: assert property (@(posedge ref_clk) disable iff (rst) // R1
      frameEnd && rxShift[cfg_mode_pkg::SPI_WRITE_BIT] && !writeBusy
      |=> cfg_mode_pkg::eccDecode(memWData ^ 13'h0010).data == $past(rxShift[7:0]))
      else $error("single bit error not corrected");
   AST_ECC_DOUBLE: assert property (@(posedge ref_clk) disable iff (rst) // R1
      frameEnd && rxShift[cfg_mode_pkg::SPI_WRITE_BIT] && !writeBusy
      |=> cfg_mode_pkg::eccDecode(memWData ^ 13'h0011).dbl)
      else $error("double bit error not flagged");
   AST_MONITOR: assert property (@(posedge ref_clk) disable iff (rst) // R12
      monHit |=> faultLatched && gates == '0) else $error("monitor hit not latched");
   AST_ACK_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // R16
      ackDet && !monHit |=> !faultLatched ##1 !faultOe) else $error("ack did not clear");
   AST_DIRECT: assert property (@(posedge ref_clk) disable iff (rst) // R9
      !blocked && directMode |=> gates.high == $past(hsF) && gates.low == $past(lsF))
      else $error("direct gate mismatch");
   AST_DEAD: assert property (@(posedge ref_clk) disable iff (rst) // R10
      !$past(directMode) && !$past(directMode, 2) && $rose(gates.low[0])
      |-> !gates.high[0] && !$past(gates.high[0]))
      else $error("no dead time");
   AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // R4
      frameEnd && rxShift[15] && !writeBusy |=> memWe ##1 writeBusy)
      else $error("store write missed");
endmodule : cfg_mode_ctrl
`default_nettype wire

// ---- hw/cfg_mode_pkg.sv ----
// Shared constants, types and error-correction functions for the configuration mode controller
`default_nettype none
package cfg_mode_pkg;
   localparam int CLK_PERIOD_NS    = 8;
   localparam int TCLK_NS          = 125;
   localparam int TICK_DIV         = (TCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_MIN_US     = 256;
   localparam int PULSE_MAX_US     = 512;
   localparam int PULSE_MIN_TICKS  = PULSE_MIN_US * 1000 / TCLK_NS;
   localparam int PULSE_MAX_TICKS  = PULSE_MAX_US * 1000 / TCLK_NS;
   localparam int LOW_CNT_W        = 13;
   localparam int REPORT_LOW_TICKS = 16;
   localparam int REPORT_HI_TICKS  = 16;
   localparam int REPORT_CNT_W     = 6;
   localparam int WRITE_CNT_W      = 12;
   localparam int SPI_FRAME_BITS   = 16;
   localparam int SPI_WRITE_BIT    = 15;
   localparam int SPI_ADDR_LSB     = 8;
   localparam int DATA_W           = 8;
   localparam int CODE_W           = 13;
   localparam int SYNC_W           = 24;
   localparam logic [DATA_W-1:0] DEAD_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_CONFIG = 2'b01,
      ST_FINISH = 2'b10,
      ST_LOAD   = 2'b11
   } mode_t;

   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } gates_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              corrected;
      logic              dbl;
   } ecc_res_t;

   // Hamming code over positions 1..12 plus overall parity in the top bit
   function automatic logic [CODE_W-1:0] eccEncode(input logic [DATA_W-1:0] d);
      logic [CODE_W-1:0] c;
      int                k;
      c = '0;
      k = 0;
      for (int p = 1; p <= 12; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p-1] = d[k];
            k++;
         end
      end
      for (int b = 0; b < 4; b++) begin
         for (int p = 1; p <= 12; p++) begin
            if (p[b] && (p != (1 << b))) begin
               c[(1<<b)-1] = c[(1<<b)-1] ^ c[p-1];
            end
         end
      end
      c[12] = ^c[11:0];
      return c;
   endfunction : eccEncode

   function automatic ecc_res_t eccDecode(input logic [CODE_W-1:0] cw);
      logic [CODE_W-1:0] c;
      logic [3:0]        syn;
      logic              oddPar;
      ecc_res_t          r;
      int                k;
      c = cw;
      syn = 4'h0;
      r = '0;
      k = 0;
      for (int p = 1; p <= 12; p++) begin
         if (c[p-1]) begin
            syn = syn ^ p[3:0];
         end
      end
      oddPar = ^c;
      if (oddPar) begin
         r.corrected = 1'b1;
         if (syn != 4'h0 && syn <= 4'hc) begin
            c[syn-4'h1] = ~c[syn-4'h1];
         end else if (syn != 4'h0) begin
            r.dbl = 1'b1;
         end
      end else if (syn != 4'h0) begin
         r.dbl = 1'b1;
      end
      for (int p = 1; p <= 12; p++) begin
         if ((p & (p - 1)) != 0) begin
            r.data[k] = c[p-1];
            k++;
         end
      end
      return r;
   endfunction : eccDecode
endpackage : cfg_mode_pkg
`default_nettype wire

// ---- hw/cfg_store.sv ----
// Nonvolatile configuration store array with registered read data
`timescale 1ns/1ps
`default_nettype none
module cfg_store #(
   parameter int AW = 4,
   parameter int DW = 13
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] wAddr,
   input  wire logic [DW-1:0] wData,
   input  wire logic [AW-1:0] rAddr,
   output logic      [DW-1:0] rData
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[wAddr] <= wData;
      end
   end

   always_ff @(posedge clk) begin
      rData <= mem[rAddr];
   end
endmodule : cfg_store
`default_nettype wire

// ---- test/host_model.sv ----
// Host side of the open-drain fault line, with the line's pull-up
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic ref_clk,
   input  wire logic faultOe,
   output logic      faultIn
);
   logic hostPull = 1'b0;
   // Pulled up unless either party pulls it low
   assign faultIn = ~(faultOe | hostPull);
   // Low pulse: configuration request or fault acknowledge
   task automatic pulse(input int cycles);
      @(posedge ref_clk);
      hostPull <= 1'b1;
      repeat (cycles) @(posedge ref_clk);
      hostPull <= 1'b0;
   endtask : pulse
endmodule : host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the configuration mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0, rst = 1'b1, driveEnable = 1'b0, sleepReq = 1'b0;
   logic spiClk = 1'b0, spiSelN = 1'b1, spiMosi = 1'b0;
   logic [2:0] highSideIn = 3'h7, lowSideIn = 3'h0;
   logic [5:0] drainSourceFlag = 6'h00, gateSourceFlag = 6'h00;
   logic faultIn, faultOut, faultOe, spiMiso, spiMisoOe, gateDischarge, configActive;
   logic faultLatched;
   cfg_mode_pkg::gates_t gates;
   logic [15:0][7:0] cfgWords;
   int mismatches = 0, n_checks = 0;
   always #4 ref_clk = ~ref_clk;
   cfg_mode_ctrl #(.DEPTH(16), .WRITE_TICKS(2)) dut (.ref_clk(ref_clk), .rst(rst),
      .driveEnable(driveEnable), .faultIn(faultIn), .faultOut(faultOut), .faultOe(faultOe),
      .highSideIn(highSideIn), .lowSideIn(lowSideIn), .spiClk(spiClk), .spiSelN(spiSelN),
      .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .sleepReq(sleepReq),
      .drainSourceFlag(drainSourceFlag), .gateSourceFlag(gateSourceFlag), .gates(gates),
      .gateDischarge(gateDischarge), .configActive(configActive),
      .faultLatched(faultLatched), .cfgWords(cfgWords));
   host_model host (.ref_clk(ref_clk), .faultOe(faultOe), .faultIn(faultIn));
   task automatic stop_test();
      $display("TB: checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic done(input string name);
      $display("TB: test %s done", name);
   endtask : done
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : settle
   // Mode 0 frame, MSB first; miso sampled just before each rising spiClk
   task automatic spiFrame(input logic [15:0] tx, output logic [15:0] rx);
      @(posedge ref_clk) spiSelN <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spiMosi <= tx[i];
         settle(6);
         rx[i] = spiMiso;
         spiClk <= 1'b1;
         settle(6);
         spiClk <= 1'b0;
      end
      check("misoOe", 16'h1, {15'h0, spiMisoOe});
      settle(6);
      spiSelN <= 1'b1;
      settle(60);
   endtask : spiFrame
   // Gates stay off while the device holds the fault line for the load
   task automatic waitLoad();
      for (int i = 0; i < 300 && faultOe === 1'b1; i++) begin
         check("gatesBlocked", 16'h0, {10'h0, gates});
         @(posedge ref_clk);
      end
      check("loadDone", 16'h0, {15'h0, faultOe});
   endtask : waitLoad
   initial begin
      settle(90000);
      mismatches++;
      stop_test();
   end
   initial begin
      logic [15:0] rx;
      logic [7:0]  dead;
      logic [2:0]  hi, lo;
      void'($urandom(32'h5a3f));
      settle(12);
      check("faultOeInReset", 16'h1, {15'h0, faultOe});
      check("faultOutLow", 16'h0, {15'h0, faultOut});
      rst <= 1'b0;
      settle(2);
      waitLoad();
      done("reset");
      // Enable low, high inputs high, low inputs low, no fault pending
      host.pulse(1000 * 16);
      settle(20);
      check("shortPulse", 16'h0, {15'h0, configActive});
      host.pulse(2500 * 16);
      settle(20);
      check("enterConfig", 16'h1, {15'h0, configActive});
      dead = 8'h04 + 8'($urandom % 16);
      spiFrame({8'h80, dead}, rx);
      spiFrame(16'h0000, rx);
      spiFrame(16'h0000, rx);
      check("storeRead", {8'h00, dead}, rx);
      done("config");
      highSideIn <= 3'h0;
      driveEnable <= 1'b1;
      settle(8);
      check("exitHoldLow", 16'h1, {15'h0, faultOe});
      waitLoad();
      check("leftConfig", 16'h0, {15'h0, configActive});
      check("deadCopied", {8'h00, dead}, {8'h00, cfgWords[0]});
      for (int k = 0; k < 8; k++) begin
         hi = 3'($urandom % 7);
         lo = 3'($urandom);
         highSideIn <= hi;
         lowSideIn <= lo;
         settle(10);
         check("directGates", {10'h0, hi, lo}, {10'h0, gates});
      end
      driveEnable <= 1'b0;
      settle(10);
      check("enableOff", 16'h0, {10'h0, gates});
      driveEnable <= 1'b1;
      highSideIn <= 3'h7;
      for (int k = 0; k < 8; k++) begin
         lo = (k == 0) ? 3'h7 : 3'($urandom);
         lowSideIn <= lo;
         settle(int'(dead) + 12);
         check("threeInput", {10'h0, ~lo, lo}, {10'h0, gates});
      end
      done("gates");
      driveEnable <= 1'b0;
      settle(10);
      sleepReq <= 1'b1;
      settle(10);
      check("discharge", 16'h1, {15'h0, gateDischarge});
      check("sleepGates", 16'h0, {10'h0, gates});
      sleepReq <= 1'b0;
      driveEnable <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) drainSourceFlag <= 6'h01 << ($urandom % 6);
         else gateSourceFlag <= 6'h01 << ($urandom % 6);
         settle(10);
         check("faultSet", 16'h1, {15'h0, faultLatched});
         check("faultGates", 16'h0, {10'h0, gates});
         drainSourceFlag <= 6'h00;
         gateSourceFlag <= 6'h00;
         host.pulse(700);
         settle(20);
         check("faultCleared", 16'h0, {15'h0, faultLatched});
         check("lineReleased", 16'h0, {15'h0, faultOe});
      end
      done("fault");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
